// file: design/fifo_level_if.sv
// fill levels, programmed thresholds and their comparisons shared by the control block
interface fifo_level_if;
  logic [4:0] rxLevel;
  logic [4:0] txLevel;
  logic [1:0] receiveTriggerLevel;
  logic [1:0] transmitEmptyThreshold;
  logic       queueEnable;
  logic       threshModeEn;
  logic       rxHit;
  logic       rxAny;
  logic       txHit;
  logic       txEmpty;
  logic       rxDataPending;
  logic       holdingEmptyPending;
  modport ctl (output rxLevel, txLevel, receiveTriggerLevel, transmitEmptyThreshold,
               output queueEnable, threshModeEn,
               input  rxHit, rxAny, txHit, txEmpty, rxDataPending, holdingEmptyPending);
  modport cmp (input  rxLevel, txLevel, receiveTriggerLevel, transmitEmptyThreshold,
               input  queueEnable, threshModeEn,
               output rxHit, rxAny, txHit, txEmpty, rxDataPending, holdingEmptyPending);
  modport pri (input  rxDataPending, holdingEmptyPending);
endinterface : fifo_level_if

// file: design/int_priority.sv
// picks the highest priority pending interrupt and encodes its identity
`include "uart_fifo_ctrl_map.svh"
module int_priority (
  fifo_level_if.pri lvl,
  input  wire logic       lineStatusPending,
  input  wire logic       timeoutPending,
  input  wire logic       busyPending,
  output logic [3:0]      interruptIdentity
);
  always_comb begin
    if (lineStatusPending) begin
      interruptIdentity = `ID_LINE_STATUS;
    end else if (lvl.rxDataPending) begin
      interruptIdentity = `ID_RX_DATA;
    end else if (timeoutPending) begin
      interruptIdentity = `ID_CHAR_TIMEOUT;
    end else if (lvl.holdingEmptyPending) begin
      interruptIdentity = `ID_HOLDING_EMPTY;
    end else if (busyPending) begin
      interruptIdentity = `ID_BUSY;
    end else begin
      interruptIdentity = `ID_NONE;
    end
  end
endmodule : int_priority

// file: design/level_compare.sv
// compares fifo fill levels against the programmed trigger and empty thresholds
module level_compare (
  fifo_level_if.cmp lvl
);
  always_comb begin
    lvl.rxHit   = lvl.rxLevel >=
                  uart_fifo_ctrl_pkg::rx_trigger_count(lvl.receiveTriggerLevel);
    lvl.rxAny   = lvl.rxLevel != 5'h00;
    lvl.txHit   = lvl.txLevel <=
                  uart_fifo_ctrl_pkg::tx_threshold_count(lvl.transmitEmptyThreshold);
    lvl.txEmpty = lvl.txLevel == 5'h00;
    // trigger levels only mean something while the queues are on
    lvl.rxDataPending       = lvl.queueEnable ? lvl.rxHit : lvl.rxAny;
    lvl.holdingEmptyPending = (lvl.queueEnable && lvl.threshModeEn) ? lvl.txHit
                                                                    : lvl.txEmpty;
  end
endmodule : level_compare

// file: design/uart_fifo_ctrl.sv
// interrupt identity and fifo control register of a serial port, on an axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "uart_fifo_ctrl_map.svh"
// What this block does
// - read bits 7:6 show 00 off, 11 on
// - write 7:6 picks receive trigger fill level
// - auto flow: trigger level drops request-to-send
// - receive dma request follows trigger in mode 1
// - write 5:4 sets transmit empty threshold; read zero
// - transmit dma request follows threshold in mode 1
// - write bit 3 selects dma mode, resets 0
// - read low nibble gives pending interrupt identity
// - bit 2 pulses transmit queue reset, self-clearing
// - bit 1 pulses receive queue reset, self-clearing
// - bit 0 enables queues; change resets both
// - priority: line status, receive data, timeout, holding empty, busy
module uart_fifo_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [4:0]  rxLevel,
  input  wire logic [4:0]  txLevel,
  input  wire logic        autoFlowEn,
  input  wire logic        rtsRequest,
  input  wire logic        threshModeEn,
  input  wire logic        lineStatusPending,
  input  wire logic        timeoutPending,
  input  wire logic        busyPending,
  output logic             rtsN,
  output logic             dmaRxReqN,
  output logic             dmaTxReqN,
  output logic             transmitQueueReset,
  output logic             receiveQueueReset,
  output logic             irq
);
  uart_fifo_ctrl_pkg::ctrl_state_t state_r;
  uart_fifo_ctrl_pkg::ctrl_state_t state_nxt;
  logic [3:0]                      interruptIdentity;
  logic [3:0]                      evtSet;
  logic [3:0]                      evtClr;
  logic [7:0]                      wrByte;
  logic                            doWrite;
  logic                            arFire;
  logic                            ctrlRead;
  logic                            ctrlWrite;
  logic                            rxDmaLevel;
  logic                            txDmaLevel;

  fifo_level_if lvl ();

  assign lvl.rxLevel                = rxLevel;
  assign lvl.txLevel                = txLevel;
  assign lvl.receiveTriggerLevel    = state_r.receiveTriggerLevel;
  assign lvl.transmitEmptyThreshold = state_r.transmitEmptyThreshold;
  assign lvl.queueEnable            = state_r.queueEnable;
  assign lvl.threshModeEn           = threshModeEn;

  level_compare u_compare (
    .lvl (lvl.cmp)
  );

  int_priority u_priority (
    .lvl               (lvl.pri),
    .lineStatusPending (lineStatusPending),
    .timeoutPending    (timeoutPending),
    .busyPending       (busyPending),
    .interruptIdentity (interruptIdentity)
  );

  assign arFire   = arvalid && state_r.arReady;
  assign ctrlRead = arFire && (araddr == `ADDR_INT_ID_FIFO_CTRL);

  // mode 1 uses the programmed levels; mode 0 or queues off uses any data / empty
  assign rxDmaLevel = (state_r.dmaSignallingSelect && state_r.queueEnable) ? lvl.rxHit
                                                                          : lvl.rxAny;
  assign txDmaLevel = (state_r.dmaSignallingSelect && state_r.queueEnable) ? lvl.txHit
                                                                          : lvl.txEmpty;

  always_comb begin
    state_nxt       = state_r;
    state_nxt.txRst = 1'b0;
    state_nxt.rxRst = 1'b0;
    evtClr          = 4'h0;
    ctrlWrite       = 1'b0;

    // write channel: address and data taken in either order, one write in flight
    if (state_r.bValid && bready) begin
      state_nxt.bValid  = 1'b0;
      state_nxt.awTaken = 1'b0;
      state_nxt.wTaken  = 1'b0;
    end
    if (awvalid && state_r.awReady) begin
      state_nxt.awTaken = 1'b1;
      state_nxt.awAddr  = awaddr;
    end
    if (wvalid && state_r.wReady) begin
      state_nxt.wTaken = 1'b1;
      state_nxt.wData  = wdata;
      state_nxt.wStrb  = wstrb;
    end
    state_nxt.awReady = !state_nxt.awTaken;
    state_nxt.wReady  = !state_nxt.wTaken;
    doWrite = state_nxt.awTaken && state_nxt.wTaken && !state_r.bValid;
    wrByte  = state_nxt.wData[7:0];

    if (doWrite) begin
      state_nxt.bValid = 1'b1;
      state_nxt.bResp  = `RESP_OKAY;
      case (state_nxt.awAddr)
        `ADDR_INT_ID_FIFO_CTRL: begin
          // only control fields are written; status view is rebuilt on read
          if (state_nxt.wStrb[0]) begin
            ctrlWrite = 1'b1;
            state_nxt.receiveTriggerLevel    =
              wrByte[`FLD_RX_TRIG_HI:`FLD_RX_TRIG_LO];
            state_nxt.transmitEmptyThreshold =
              wrByte[`FLD_TX_THR_HI:`FLD_TX_THR_LO];
            state_nxt.dmaSignallingSelect    = wrByte[`FLD_DMA_SEL];
            state_nxt.queueEnable            = wrByte[`FLD_QUEUE_EN];
            // reset strobes are held for one cycle only, so they need no clearing write
            state_nxt.txRst = wrByte[`FLD_TX_RESET] ||
                              (wrByte[`FLD_QUEUE_EN] != state_r.queueEnable);
            state_nxt.rxRst = wrByte[`FLD_RX_RESET] ||
                              (wrByte[`FLD_QUEUE_EN] != state_r.queueEnable);
          end
        end
        `ADDR_EVT_CLEAR: begin
          if (state_nxt.wStrb[0]) begin
            evtClr = wrByte[3:0];
          end
        end
        `ADDR_EVT_ENABLE: begin
          if (state_nxt.wStrb[0]) begin
            state_nxt.evtEnable = wrByte[3:0];
          end
        end
        `ADDR_EVT_STATUS, `ADDR_LEVEL_STATUS: begin
          state_nxt.bResp = `RESP_OKAY;
        end
        default: begin
          state_nxt.bResp = `RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read in flight, answer one edge after the address
    if (state_r.rValid && rready) begin
      state_nxt.rValid = 1'b0;
    end
    if (arFire) begin
      state_nxt.rValid = 1'b1;
      state_nxt.rResp  = `RESP_OKAY;
      case (araddr)
        `ADDR_INT_ID_FIFO_CTRL: begin
          state_nxt.rData = {24'h00_0000, {2{state_r.queueEnable}}, 2'h0,
                             interruptIdentity};
        end
        `ADDR_EVT_STATUS: begin
          state_nxt.rData = {28'h000_0000, state_r.evtStatus};
        end
        `ADDR_EVT_CLEAR: begin
          state_nxt.rData = 32'h0000_0000;
        end
        `ADDR_EVT_ENABLE: begin
          state_nxt.rData = {28'h000_0000, state_r.evtEnable};
        end
        `ADDR_LEVEL_STATUS: begin
          state_nxt.rData = {19'h0_0000, rxLevel, 3'h0, txLevel};
        end
        default: begin
          state_nxt.rData = 32'h0000_0000;
          state_nxt.rResp = `RESP_SLVERR;
        end
      endcase
    end
    state_nxt.arReady = !state_nxt.rValid;

    // events: rising edges of the receive data, holding empty and line status pending levels plus completed queue resets
    evtSet[0] = lvl.rxDataPending && !state_r.rxDataSeen;
    evtSet[1] = lvl.holdingEmptyPending && !state_r.holdingEmptySeen;
    evtSet[2] = state_r.txRst || state_r.rxRst;
    evtSet[3] = lineStatusPending && !state_r.lineStatusSeen;
    state_nxt.rxDataSeen       = lvl.rxDataPending;
    state_nxt.holdingEmptySeen = lvl.holdingEmptyPending;
    state_nxt.lineStatusSeen   = lineStatusPending;
    // set beats clear so an event landing on the clear write is kept
    state_nxt.evtStatus = (state_r.evtStatus & ~evtClr) | evtSet;
    state_nxt.irq       = |(state_nxt.evtStatus & state_nxt.evtEnable);

    // rts is held off once the receive queue reaches its trigger
    if (autoFlowEn && state_r.queueEnable) begin
      state_nxt.rtsN = lvl.rxHit || !rtsRequest;
    end else begin
      state_nxt.rtsN = !rtsRequest;
    end
    state_nxt.dmaRxReqN = !rxDmaLevel;
    state_nxt.dmaTxReqN = !txDmaLevel;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r                        <= '0;
      state_r.receiveTriggerLevel    <= `RESET_RX_TRIG;
      state_r.transmitEmptyThreshold <= `RESET_TX_THR;
      state_r.dmaSignallingSelect    <= `RESET_DMA_SEL;
      state_r.queueEnable            <= `RESET_QUEUE_EN;
      state_r.rtsN                   <= 1'b1;
      state_r.dmaRxReqN              <= 1'b1;
      state_r.dmaTxReqN              <= 1'b1;
      // transmit side idles empty, so no false holding-empty event after reset
      state_r.holdingEmptySeen       <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign awready            = state_r.awReady;
  assign wready             = state_r.wReady;
  assign bvalid             = state_r.bValid;
  assign bresp              = state_r.bResp;
  assign arready            = state_r.arReady;
  assign rvalid             = state_r.rValid;
  assign rdata              = state_r.rData;
  assign rresp              = state_r.rResp;
  assign rtsN               = state_r.rtsN;
  assign dmaRxReqN          = state_r.dmaRxReqN;
  assign dmaTxReqN          = state_r.dmaTxReqN;
  assign transmitQueueReset = state_r.txRst;
  assign receiveQueueReset  = state_r.rxRst;
  assign irq                = state_r.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_STATUS_BITS_READ: assert property (
    ctrlRead |=> rdata[7:6] == {2{$past(state_r.queueEnable)}} && rvalid)
    else $error("fifo enabled status wrong on read");

  AST_RX_TRIGGER_WRITE: assert property (
    ctrlWrite |=> state_r.receiveTriggerLevel == $past(wrByte[7:6]))
    else $error("receive trigger field not stored");

  AST_RTS_DROPS_AT_TRIGGER: assert property (
    autoFlowEn && state_r.queueEnable && lvl.rxHit |=> rtsN)
    else $error("rts still asserted at receive trigger");

  AST_RX_DMA_MODE1: assert property (
    state_r.dmaSignallingSelect && state_r.queueEnable && !lvl.rxHit && lvl.rxAny
      |=> dmaRxReqN)
    else $error("receive dma request before trigger in mode 1");

  AST_TX_BITS_READ_ZERO: assert property (
    ctrlRead |=> rdata[5:4] == 2'h0)
    else $error("threshold bits do not read as zero");

  AST_TX_DMA_LEVEL: assert property (
    state_r.dmaSignallingSelect && state_r.queueEnable && lvl.txHit |=> !dmaTxReqN)
    else $error("transmit dma request missing at threshold");

  AST_DMA_SELECT_WRITE: assert property (
    ctrlWrite |=> state_r.dmaSignallingSelect == $past(wrByte[3]))
    else $error("dma select bit not stored");

  AST_ID_READ: assert property (
    ctrlRead |=> rdata[3:0] == $past(interruptIdentity) && rresp == `RESP_OKAY)
    else $error("interrupt identity wrong on read");

  AST_TX_RESET_SELF_CLEAR: assert property (
    ctrlWrite && wrByte[2] |=> transmitQueueReset ##1 (!transmitQueueReset)[*2])
    else $error("transmit queue reset not a single pulse");

  AST_RX_RESET_PULSE: assert property (
    ctrlWrite && wrByte[1] |=> receiveQueueReset ##1 !receiveQueueReset)
    else $error("receive queue reset not a single pulse");

  AST_ENABLE_CHANGE_RESETS: assert property (
    ctrlWrite && (wrByte[0] != state_r.queueEnable)
      |=> transmitQueueReset && receiveQueueReset && state_r.queueEnable == $past(wrByte[0]))
    else $error("enable change did not reset both queues");

  AST_LINE_STATUS_FIRST: assert property (
    lineStatusPending && (lvl.rxDataPending || lvl.holdingEmptyPending)
      |-> interruptIdentity == `ID_LINE_STATUS)
    else $error("line status not highest priority");

  AST_READ_LEAVES_CONTROL: assert property (
    ctrlRead && !ctrlWrite
      |=> $stable({state_r.receiveTriggerLevel, state_r.transmitEmptyThreshold,
                   state_r.dmaSignallingSelect, state_r.queueEnable}))
    else $error("read changed control fields");

  AST_WRITE_ANSWERED: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  AST_QUEUE_RESET_ONE_CYCLE: assert property (
    transmitQueueReset || receiveQueueReset |=> !transmitQueueReset && !receiveQueueReset)
    else $error("queue reset pulse longer than one cycle");

  AST_RTS_FOLLOWS_REQUEST: assert property (
    !autoFlowEn |=> rtsN == !$past(rtsRequest))
    else $error("rts does not follow software request");

  AST_READ_DATA_HELD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before it was taken");

  AST_EVENT_SET_WINS: assert property (
    evtSet != 4'h0 |=> (state_r.evtStatus & $past(evtSet)) == $past(evtSet))
    else $error("event lost against a clear");

  AST_IRQ_FROM_STATUS: assert property (
    irq == (|(state_r.evtStatus & state_r.evtEnable)))
    else $error("irq does not match enabled status");

  AST_UPPER_READ_ZERO: assert property (
    ctrlRead |=> rdata[31:8] == 24'h00_0000)
    else $error("upper bits of identity read not zero");

  CVR_CTRL_WRITE: cover property (ctrlWrite ##1 transmitQueueReset);
  CVR_CTRL_READ: cover property (ctrlRead ##1 rvalid ##[0:4] rready);
  CVR_IRQ_RAISED: cover property (!irq ##1 irq);
  CVR_RTS_HELD: cover property (autoFlowEn && rtsRequest ##1 rtsN);
  CVR_DMA_MODE1: cover property (state_r.dmaSignallingSelect && !dmaTxReqN);
endmodule : uart_fifo_ctrl

// file: design/uart_fifo_ctrl_map.svh
// register map, field positions, codes and fixed counts of the fifo control block
`ifndef UART_FIFO_CTRL_MAP_SVH
`define UART_FIFO_CTRL_MAP_SVH
`define ADDR_INT_ID_FIFO_CTRL 32'h5000_1108
`define ADDR_EVT_STATUS       32'h5000_1140
`define ADDR_EVT_CLEAR        32'h5000_1144
`define ADDR_EVT_ENABLE       32'h5000_1148
`define ADDR_LEVEL_STATUS     32'h5000_114c
`define FLD_RX_TRIG_HI        7
`define FLD_RX_TRIG_LO        6
`define FLD_TX_THR_HI         5
`define FLD_TX_THR_LO         4
`define FLD_DMA_SEL           3
`define FLD_TX_RESET          2
`define FLD_RX_RESET          1
`define FLD_QUEUE_EN          0
`define RESET_RX_TRIG         2'h0
`define RESET_TX_THR          2'h0
`define RESET_DMA_SEL         1'h0
`define RESET_QUEUE_EN        1'h0
`define ID_NONE               4'h1
`define ID_HOLDING_EMPTY      4'h2
`define ID_RX_DATA            4'h4
`define ID_LINE_STATUS        4'h6
`define ID_BUSY               4'h7
`define ID_CHAR_TIMEOUT       4'hc
`define RX_TRIG_ONE           5'h01
`define RX_TRIG_QUARTER       5'h04
`define RX_TRIG_HALF          5'h08
`define RX_TRIG_NEAR_FULL     5'h0e
`define TX_THR_EMPTY          5'h00
`define TX_THR_TWO            5'h02
`define TX_THR_QUARTER        5'h04
`define TX_THR_HALF           5'h08
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2
`endif

// file: design/uart_fifo_ctrl_pkg.sv
// types and level decode functions of the fifo control block
`include "uart_fifo_ctrl_map.svh"
package uart_fifo_ctrl_pkg;
  typedef struct packed {
    logic        awReady;
    logic        awTaken;
    logic [31:0] awAddr;
    logic        wReady;
    logic        wTaken;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [1:0]  receiveTriggerLevel;
    logic [1:0]  transmitEmptyThreshold;
    logic        dmaSignallingSelect;
    logic        queueEnable;
    logic        txRst;
    logic        rxRst;
    logic [3:0]  evtStatus;
    logic [3:0]  evtEnable;
    logic        rxDataSeen;
    logic        holdingEmptySeen;
    logic        lineStatusSeen;
    logic        rtsN;
    logic        dmaRxReqN;
    logic        dmaTxReqN;
    logic        irq;
  } ctrl_state_t;

  function automatic logic [4:0] rx_trigger_count(input logic [1:0] code);
    case (code)
      2'h0:    rx_trigger_count = `RX_TRIG_ONE;
      2'h1:    rx_trigger_count = `RX_TRIG_QUARTER;
      2'h2:    rx_trigger_count = `RX_TRIG_HALF;
      default: rx_trigger_count = `RX_TRIG_NEAR_FULL;
    endcase
  endfunction : rx_trigger_count

  function automatic logic [4:0] tx_threshold_count(input logic [1:0] code);
    case (code)
      2'h0:    tx_threshold_count = `TX_THR_EMPTY;
      2'h1:    tx_threshold_count = `TX_THR_TWO;
      2'h2:    tx_threshold_count = `TX_THR_QUARTER;
      default: tx_threshold_count = `TX_THR_HALF;
    endcase
  endfunction : tx_threshold_count
endpackage : uart_fifo_ctrl_pkg

// file: test/fifo_level_model.sv
// fill levels of the receive and transmit queues, as the serial side holds them
module fifo_level_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [4:0] rxSet,
  input  wire logic [4:0] txSet,
  input  wire logic       receiveQueueReset,
  input  wire logic       transmitQueueReset,
  output logic      [4:0] rxLevel,
  output logic      [4:0] txLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxLevel <= 5'h00;
      txLevel <= 5'h00;
    end else begin
      // a queue reset wins over a new fill, so the queue reads empty after it
      if (receiveQueueReset) rxLevel <= 5'h00;
      else if (load) rxLevel <= rxSet;
      if (transmitQueueReset) txLevel <= 5'h00;
      else if (load) txLevel <= txSet;
    end
  end
endmodule : fifo_level_model

// file: test/uart_fifo_ctrl_tb.sv
// self-checking bench of the interrupt identity and fifo control register block
`include "uart_fifo_ctrl_map.svh"
module uart_fifo_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset, awvalid, wvalid, bready, arvalid, rready, load;
  logic [31:0] awaddr, wdata, araddr, rdVal;
  logic [3:0]  wstrb;
  logic [1:0]  lastResp, rdResp;
  logic        autoFlowEn, rtsRequest, threshModeEn;
  logic        lineStatusPending, timeoutPending, busyPending;
  logic [4:0]  rxSet, txSet;
  wire logic   awready, wready, bvalid, arready, rvalid, rtsN, dmaRxReqN, dmaTxReqN, irq;
  wire logic   transmitQueueReset, receiveQueueReset;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0]  rxLevel, txLevel;
  int          err_count, compares, txPulses, rxPulses;
  localparam logic [31:0] CTRL = `ADDR_INT_ID_FIFO_CTRL;
  // fill counts for a 16-entry queue
  logic [4:0]  trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  logic [4:0]  thr  [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
  logic [2:0]  srcv [6] = '{3'h7, 3'h3, 3'h3, 3'h1, 3'h1, 3'h0};
  logic [4:0]  rxv  [6] = '{5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [4:0]  txv  [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h05, 5'h05};
  logic [3:0]  idv  [6] = '{4'h6, 4'h4, 4'hc, 4'h2, 4'h7, 4'h1};

  uart_fifo_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxLevel(rxLevel), .txLevel(txLevel), .autoFlowEn(autoFlowEn), .rtsRequest(rtsRequest),
    .threshModeEn(threshModeEn), .lineStatusPending(lineStatusPending),
    .timeoutPending(timeoutPending), .busyPending(busyPending), .rtsN(rtsN),
    .dmaRxReqN(dmaRxReqN), .dmaTxReqN(dmaTxReqN), .transmitQueueReset(transmitQueueReset),
    .receiveQueueReset(receiveQueueReset), .irq(irq));

  fifo_level_model i_levels (.ref_clk(ref_clk), .reset(reset), .load(load), .rxSet(rxSet),
    .txSet(txSet), .receiveQueueReset(receiveQueueReset),
    .transmitQueueReset(transmitQueueReset), .rxLevel(rxLevel), .txLevel(txLevel));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (transmitQueueReset === 1'b1) txPulses++;
    if (receiveQueueReset === 1'b1) rxPulses++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    int n = 0;
    @(posedge ref_clk);
    awaddr  <= addr;
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    lastResp = bresp;
    bready <= 1'b0;
    if (n >= 50) err_count++;
  endtask : wr

  task automatic rdchk(input string name, input logic [31:0] addr, input logic [31:0] exp,
                       input logic [31:0] mask = 32'hffff_ffff);
    int n = 0;
    @(posedge ref_clk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rdVal  = rdata;
    rdResp = rresp;
    rready <= 1'b0;
    if (n >= 50) err_count++;
    chk(name, rdVal & mask, exp);
  endtask : rdchk

  // outputs follow a level one edge late, the level model adds another
  task automatic setLv(input logic [4:0] rx, input logic [4:0] tx);
    @(posedge ref_clk);
    load  <= 1'b1;
    rxSet <= rx;
    txSet <= tx;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : setLv

  task automatic conclude;
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #50us;
    err_count++;
    conclude();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, load} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    {autoFlowEn, rtsRequest, threshModeEn} = 3'h0;
    {lineStatusPending, timeoutPending, busyPending} = 3'h0;
    {rxSet, txSet} = 10'h000;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk("id after reset", CTRL, 32'h0000_0002);
    chk("rts after reset", rtsN, 1'b1);
    rdchk("unmapped read", 32'h5000_1100, 32'h0);
    chk("unmapped rresp", rdResp, `RESP_SLVERR);
    wr(32'h5000_1100, 32'hff);
    chk("unmapped bresp", lastResp, `RESP_SLVERR);
    wr(`ADDR_EVT_ENABLE, 32'h4);
    wr(CTRL, 32'h01);
    @(posedge ref_clk);
    chk("enable pulses", {txPulses[15:0], rxPulses[15:0]}, 32'h0001_0001);
    rdchk("enabled id", CTRL, 32'h0000_00c2);
    wr(CTRL, 32'h05);
    wr(CTRL, 32'h03);
    @(posedge ref_clk);
    chk("queue pulses", {txPulses[15:0], rxPulses[15:0]}, 32'h0002_0002);
    chk("irq raised", irq, 1'b1);
    rdchk("event set", `ADDR_EVT_STATUS, 32'h4, 32'h4);
    wr(`ADDR_EVT_ENABLE, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(`ADDR_EVT_CLEAR, 32'h4);
    rdchk("event cleared", `ADDR_EVT_STATUS, 32'h0, 32'h4);
    rdchk("clear reads zero", `ADDR_EVT_CLEAR, 32'h0);
    autoFlowEn <= 1'b1;
    rtsRequest <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(CTRL, (c << 6) | 32'h9);
      setLv(trig[c] - 5'h01, 5'h05);
      rdchk("below trigger", CTRL, 32'h0000_00c1);
      chk("rts below", rtsN, 1'b0);
      chk("dma rx below", dmaRxReqN, 1'b1);
      setLv(trig[c], 5'h05);
      rdchk("at trigger", CTRL, 32'h0000_00c4);
      chk("rts at", rtsN, 1'b1);
      chk("dma rx at", dmaRxReqN, 1'b0);
    end
    threshModeEn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(CTRL, (c << 4) | 32'h9);
      setLv(5'h00, thr[c] + 5'h01);
      rdchk("above threshold", CTRL, 32'h0000_00c1);
      chk("dma tx above", dmaTxReqN, 1'b1);
      setLv(5'h00, thr[c]);
      rdchk("at threshold", CTRL, 32'h0000_00c2);
      chk("dma tx at", dmaTxReqN, 1'b0);
    end
    wr(CTRL, 32'h81);
    setLv(5'h01, 5'h05);
    chk("dma rx mode0", dmaRxReqN, 1'b0);
    rdchk("levels", `ADDR_LEVEL_STATUS, 32'h0000_0105);
    wr(CTRL, 32'h01);
    for (int i = 0; i < 6; i++) begin
      {lineStatusPending, timeoutPending, busyPending} <= srcv[i];
      setLv(rxv[i], txv[i]);
      rdchk("priority", CTRL, {24'h0, 4'hc, idv[i]});
    end
    conclude();
  end
endmodule : uart_fifo_ctrl_tb
